// [common/ppio_regs.vh]
// register map, reset values and timing counts of the port pin block
// assumes byte addresses on a 32-bit AXI4-Lite bus, one word per register
`ifndef PPIO_REGS_VH
`define PPIO_REGS_VH

`define PPIO_OFF_LATCH 8'h00
`define PPIO_OFF_INPUT 8'h04
`define PPIO_OFF_DIR 8'h08
`define PPIO_OFF_DRIVE 8'h0c
`define PPIO_OFF_PULLEN 8'h10
`define PPIO_OFF_POL 8'h14
`define PPIO_OFF_ODRAIN 8'h18
`define PPIO_OFF_IEN 8'h1c
`define PPIO_OFF_IFLAG 8'h20
`define PPIO_OFF_EXTCTL 8'h24
`define PPIO_OFF_STATUS 8'h28

`define PPIO_EXT_EDGE_BIT 0
`define PPIO_EXT_EN_BIT 1
`define PPIO_STS_OC_BIT 0
`define PPIO_STS_MODE_BIT 1

`define PPIO_RST_ZERO 8'h00
`define PPIO_RST_PULLEN 8'h21
`define PPIO_RST_POL 8'h00

`define PPIO_FILT_SAMPLES 3'h4
`define PPIO_SYNC_STAGES 2

`define PPIO_RESP_OKAY 2'h0
`define PPIO_RESP_SLVERR 2'h2

`endif

// [logic/ppio_edge_filter.v]
// glitch filter and edge detector for one synchronised pin
// assumes sampleIn is already synchronised to clk
`timescale 1ns/100ps
`include "ppio_regs.vh"
module ppio_edge_filter (
    clk,
    rst_b,
    sampleIn,
    risingSel,
    edgeHit
);
    input wire clk;
    input wire rst_b;
    input wire sampleIn;
    input wire risingSel;
    output reg edgeHit;

    localparam [2:0] NEED = `PPIO_FILT_SAMPLES;

    reg [2:0] passCnt_r;
    reg [2:0] actCnt_r;
    wire isActive = (sampleIn == risingSel);

    always @(posedge clk) begin
        if (!rst_b) begin
            passCnt_r <= 3'h0;
            actCnt_r <= 3'h0;
            edgeHit <= 1'b0;
        end else begin
            edgeHit <= 1'b0;
            if (!isActive) begin
                // passive sample during active run restarts the sampler
                if (actCnt_r != 3'h0) begin
                    passCnt_r <= 3'h1;
                    actCnt_r <= 3'h0;
                end else if (passCnt_r != NEED) begin
                    passCnt_r <= passCnt_r + 3'h1;
                end
            end else if (passCnt_r == NEED) begin
                if (actCnt_r == NEED - 3'h1) begin
                    edgeHit <= 1'b1;
                    passCnt_r <= 3'h0;
                    actCnt_r <= 3'h0;
                end else begin
                    actCnt_r <= actCnt_r + 3'h1;
                end
            end else begin
                passCnt_r <= 3'h0;
            end
        end
    end
endmodule

// [logic/ppio_port.v]
// holds one port of general pins with AXI4-Lite register access
// assumes pins arrive asynchronously and peripherals share clk
`timescale 1ns/100ps
`include "ppio_regs.vh"
module ppio_port #(
    parameter W = 6,
    parameter HAS_LATCH = 1,
    parameter HAS_PULL = 1,
    parameter HAS_ODRAIN = 1,
    parameter HAS_INT = 1,
    parameter EXT_PIN = 5,
    parameter NMI_PIN = 0,
    parameter OC_PIN = 2
) (
    input wire clk,
    input wire rst_b,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    input wire [7:0] s_axi_araddr,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    input wire [W-1:0] pinIn,
    output reg [W-1:0] pinOut,
    output reg [W-1:0] pinOe_b,
    output reg [W-1:0] pullUpEn,
    output reg [W-1:0] pullDnEn,
    output reg [W-1:0] lowDrive,
    input wire [W-1:0] periphOwn,
    input wire [W-1:0] periphDrive,
    input wire [W-1:0] periphOut,
    output reg [W-1:0] periphIn,
    input wire debugPinIn,
    input wire overCurrentIn,
    input wire cpuIMask,
    input wire cpuXMask,
    input wire extAck,
    output reg edgeIrq,
    output reg extIrq,
    output reg nmiIrq,
    output reg resetModeStrap
);

    localparam [7:0] RST_ZERO = `PPIO_RST_ZERO;
    localparam [7:0] RST_PULLEN = `PPIO_RST_PULLEN;
    localparam [7:0] RST_POL = `PPIO_RST_POL;

    reg [W-1:0] latch_r;
    reg [W-1:0] dir_r;
    reg [W-1:0] drive_r;
    reg [W-1:0] pullEn_r;
    reg [W-1:0] pol_r;
    reg [W-1:0] odrain_r;
    reg [W-1:0] ien_r;
    reg [W-1:0] iflag_r;
    reg [W-1:0] iflag_nxt;
    reg [1:0] extCtl_r;
    reg ocFlag_r;
    reg extPend_r;
    reg extPrev_r;
    reg [7:0] awAddr_r;
    reg awHeld_r;
    reg [31:0] wData_r;
    reg [3:0] wStrb_r;
    reg wHeld_r;

    wire [W-1:0] pinSync;
    wire [W-1:0] edgeHit;
    wire [1:0] miscSync;
    wire dbgSync = miscSync[0];
    wire ocSync = miscSync[1];

    // decode shared by read and write paths
    function mapped;
        input [7:0] a;
        begin
            case (a)
                `PPIO_OFF_LATCH, `PPIO_OFF_INPUT, `PPIO_OFF_DIR, `PPIO_OFF_DRIVE,
                `PPIO_OFF_PULLEN, `PPIO_OFF_POL, `PPIO_OFF_ODRAIN, `PPIO_OFF_IEN,
                `PPIO_OFF_IFLAG, `PPIO_OFF_EXTCTL, `PPIO_OFF_STATUS: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    endfunction

    ppio_sync #(.W(W)) u_pinSync (
        .clk(clk),
        .rst_b(rst_b),
        .d(pinIn),
        .q(pinSync)
    );

    ppio_sync #(.W(2)) u_miscSync (
        .clk(clk),
        .rst_b(1'b1), // never reset, so the strap can follow the pin during reset
        .d({overCurrentIn, debugPinIn}),
        .q(miscSync)
    );

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : gFilt
            ppio_edge_filter u_filt (
                .clk(clk),
                .rst_b(rst_b),
                .sampleIn(pinSync[g]),
                .risingSel(pol_r[g]),
                .edgeHit(edgeHit[g])
            );
        end
    endgenerate

    // write channel: address and data taken in either order
    wire doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
    wire wrLane = wStrb_r[0];
    wire [W-1:0] wrBits = wData_r[W-1:0];
    wire wrHit = doWrite && wrLane;

    always @(posedge clk) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r <= 32'h00000000;
            wStrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PPIO_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_r <= s_axi_awaddr;
                awHeld_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
                wHeld_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(awAddr_r) ? `PPIO_RESP_OKAY : `PPIO_RESP_SLVERR;
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // configuration registers, writable at any time
    always @(posedge clk) begin
        if (!rst_b) begin
            latch_r <= RST_ZERO[W-1:0];
            dir_r <= RST_ZERO[W-1:0];
            drive_r <= RST_ZERO[W-1:0];
            pullEn_r <= RST_PULLEN[W-1:0];
            pol_r <= RST_POL[W-1:0];
            odrain_r <= RST_ZERO[W-1:0];
            ien_r <= RST_ZERO[W-1:0];
            extCtl_r <= 2'h0;
        end else if (wrHit) begin
            case (awAddr_r)
                `PPIO_OFF_LATCH: if (HAS_LATCH != 0) latch_r <= wrBits;
                `PPIO_OFF_DIR: dir_r <= wrBits;
                `PPIO_OFF_DRIVE: drive_r <= wrBits;
                `PPIO_OFF_PULLEN: if (HAS_PULL != 0) pullEn_r <= wrBits;
                `PPIO_OFF_POL: pol_r <= wrBits;
                `PPIO_OFF_ODRAIN: if (HAS_ODRAIN != 0) odrain_r <= wrBits;
                `PPIO_OFF_IEN: if (HAS_INT != 0) ien_r <= wrBits;
                `PPIO_OFF_EXTCTL: extCtl_r <= wData_r[1:0];
                default: extCtl_r <= extCtl_r; // input register is not writable
            endcase
        end
    end

    // flags: hardware set beats software clear
    always @* begin
        iflag_nxt = iflag_r;
        if (wrHit && awAddr_r == `PPIO_OFF_IFLAG) begin
            iflag_nxt = iflag_nxt & ~wrBits;
        end
        iflag_nxt = iflag_nxt | edgeHit;
        if (HAS_INT == 0) begin
            iflag_nxt = {W{1'b0}};
        end
    end

    wire ocClr = wrHit && awAddr_r == `PPIO_OFF_STATUS && wData_r[`PPIO_STS_OC_BIT];
    wire extFall = extPrev_r && !pinSync[EXT_PIN];
    wire extEn = extCtl_r[`PPIO_EXT_EN_BIT];
    wire extEdgeMode = extCtl_r[`PPIO_EXT_EDGE_BIT];

    always @(posedge clk) begin
        if (!rst_b) begin
            iflag_r <= RST_ZERO[W-1:0];
            ocFlag_r <= 1'b0;
            extPend_r <= 1'b0;
            extPrev_r <= 1'b1;
            edgeIrq <= 1'b0;
            extIrq <= 1'b0;
            nmiIrq <= 1'b0;
            // strap follows the debug pin while reset is held
            resetModeStrap <= dbgSync;
        end else begin
            iflag_r <= iflag_nxt;
            ocFlag_r <= ocSync | (ocFlag_r & ~ocClr);
            extPrev_r <= pinSync[EXT_PIN];
            // pending edge drops when the enable goes away
            extPend_r <= extEn && (extFall || (extPend_r && !extAck));
            edgeIrq <= |(iflag_r & ien_r);
            extIrq <= extEn && !cpuIMask &&
                (extEdgeMode ? extPend_r : !pinSync[EXT_PIN]);
            nmiIrq <= !cpuXMask && !pinSync[NMI_PIN];
        end
    end

    // read channel, answered the cycle after the address is taken
    reg [31:0] rdVal;
    always @* begin
        rdVal = 32'h00000000;
        case (s_axi_araddr)
            `PPIO_OFF_LATCH: begin
                if (HAS_LATCH != 0) begin
                    // direction picks the source even under peripheral use
                    rdVal[W-1:0] = (dir_r & latch_r) | (~dir_r & pinSync);
                end
            end
            `PPIO_OFF_INPUT: rdVal[W-1:0] = pinSync;
            `PPIO_OFF_DIR: rdVal[W-1:0] = dir_r;
            `PPIO_OFF_DRIVE: rdVal[W-1:0] = drive_r;
            `PPIO_OFF_PULLEN: rdVal[W-1:0] = pullEn_r;
            `PPIO_OFF_POL: rdVal[W-1:0] = pol_r;
            `PPIO_OFF_ODRAIN: rdVal[W-1:0] = odrain_r;
            `PPIO_OFF_IEN: rdVal[W-1:0] = ien_r;
            `PPIO_OFF_IFLAG: rdVal[W-1:0] = iflag_r;
            `PPIO_OFF_EXTCTL: rdVal[1:0] = extCtl_r;
            `PPIO_OFF_STATUS: begin
                rdVal[`PPIO_STS_OC_BIT] = ocFlag_r;
                rdVal[`PPIO_STS_MODE_BIT] = resetModeStrap;
            end
            default: rdVal = 32'h00000000;
        endcase
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PPIO_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdVal;
                s_axi_rresp <= mapped(s_axi_araddr) ? `PPIO_RESP_OKAY : `PPIO_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // pin control; registered so every pad signal comes from a flop
    reg [W-1:0] outNxt;
    reg [W-1:0] oeNxt;
    reg [W-1:0] upNxt;
    reg [W-1:0] dnNxt;
    reg [W-1:0] lowNxt;
    reg effDir;
    reg value;
    integer i;
    always @* begin
        effDir = 1'b0;
        value = 1'b0;
        outNxt = {W{1'b0}};
        oeNxt = {W{1'b1}};
        upNxt = {W{1'b0}};
        dnNxt = {W{1'b0}};
        lowNxt = {W{1'b0}};
        for (i = 0; i < W; i = i + 1) begin
            // peripheral overrides the direction bit
            effDir = periphOwn[i] ? periphDrive[i] : dir_r[i];
            // latch reaches the pad only in general-purpose output use
            value = periphOwn[i] ? periphOut[i] : latch_r[i];
            if (HAS_LATCH == 0 && !periphOwn[i]) begin
                effDir = 1'b0;
            end
            if (i == OC_PIN && ocFlag_r) begin
                // over-current forces low until the flag is cleared
                outNxt[i] = 1'b0;
                oeNxt[i] = 1'b0;
            end else if (effDir) begin
                outNxt[i] = value;
                // wired-or: a high is released rather than driven
                oeNxt[i] = odrain_r[i] & value;
                lowNxt[i] = drive_r[i];
            end
            if (pullEn_r[i]) begin
                if (!effDir) begin
                    upNxt[i] = ~pol_r[i];
                    dnNxt[i] = pol_r[i];
                end else if (odrain_r[i]) begin
                    upNxt[i] = ~pol_r[i];
                end
            end
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            pinOut <= {W{1'b0}};
            pinOe_b <= {W{1'b1}};
            pullUpEn <= {W{1'b0}};
            pullDnEn <= {W{1'b0}};
            lowDrive <= {W{1'b0}};
            periphIn <= {W{1'b0}};
        end else begin
            pinOut <= outNxt;
            pinOe_b <= oeNxt;
            pullUpEn <= upNxt;
            pullDnEn <= dnNxt;
            lowDrive <= lowNxt;
            periphIn <= pinSync;
        end
    end
endmodule

// [logic/ppio_sync.v]
// two-flop synchroniser for a vector of pin levels
// assumes each bit is an independent level from outside the clock domain
`timescale 1ns/100ps
module ppio_sync #(
    parameter W = 1
) (
    clk,
    rst_b,
    d,
    q
);
    input wire clk;
    input wire rst_b;
    input wire [W-1:0] d;
    output reg [W-1:0] q;

    reg [W-1:0] meta_r;

    // meta_r feeds q only
    always @(posedge clk) begin
        if (!rst_b) begin
            meta_r <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// [tb/ppio_checker_assertions.sv]
// concurrent checks on the port pin block top level
// assumes one clk domain, synchronous active-low rst_b
`timescale 1ns/100ps
module ppio_checker #(
    parameter W = 6
) (
    input logic clk,
    input logic rst_b,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [1:0] s_axi_bresp,
    input logic [W-1:0] pullUpEn,
    input logic [W-1:0] pullDnEn,
    input logic [W-1:0] pinOe_b,
    input logic [W-1:0] periphOwn,
    input logic [W-1:0] periphDrive,
    input logic cpuIMask,
    input logic cpuXMask,
    input logic extIrq,
    input logic nmiIrq,
    input logic resetModeStrap
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    property p_rdAns;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rdAns: assert property (p_rdAns) else $error("read not answered");
    property p_rdHold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rdHold: assert property (p_rdHold) else $error("read data moved");
    property p_bHold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bHold: assert property (p_bHold) else $error("write answer moved");
    property p_pullX;
        (pullUpEn & pullDnEn) == '0;
    endproperty
    a_pullX: assert property (p_pullX) else $error("both pulls on");
    property p_nmi;
        cpuXMask && $past(cpuXMask) |-> !nmiIrq;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi while masked");
    property p_ext;
        cpuIMask ##1 cpuIMask |-> !extIrq;
    endproperty
    a_ext: assert property (p_ext) else $error("ext request while masked");
    property p_strap;
        rst_b && $past(rst_b) |-> $stable(resetModeStrap);
    endproperty
    a_strap: assert property (p_strap) else $error("strap moved");
    property p_own;
        periphOwn[W-1] && !periphDrive[W-1] |-> ##[1:2] pinOe_b[W-1];
    endproperty
    a_own: assert property (p_own) else $error("owned input driven");
endmodule

bind ppio_port ppio_checker #(.W(W)) ppio_checker_inst (.clk, .rst_b, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .pullUpEn, .pullDnEn, .pinOe_b, .periphOwn,
    .periphDrive, .cpuIMask, .cpuXMask, .extIrq, .nmiIrq, .resetModeStrap);

// [tb/ppio_pin_model.sv]
// pads and outside world of one port
// assumes the bench drives extLevel only where extDrive is set
`timescale 1ns/100ps
module ppio_pin_model #(
    parameter W = 6
) (
    input logic clk,
    input logic [W-1:0] pinOut,
    input logic [W-1:0] pinOe_b,
    input logic [W-1:0] pullUpEn,
    input logic [W-1:0] pullDnEn,
    input logic [W-1:0] extLevel,
    input logic [W-1:0] extDrive,
    output logic [W-1:0] pinIn
);
    logic [W-1:0] flip = '0;
    // a floating pad toggles, too fast to pass the edge filter
    always @(posedge clk) flip <= ~flip;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pinIn[i] = !pinOe_b[i] ? pinOut[i] : extDrive[i] ? extLevel[i] :
                pullUpEn[i] ? 1'b1 : pullDnEn[i] ? 1'b0 : flip[i];
        end
    end
endmodule

// [tb/tb.sv]
// top bench: random and directed register traffic on one port
// assumes the pin model closes the pad loop, W of 6
`timescale 1ns/100ps
`include "ppio_regs.vh"
module tb;
    logic clk = 0, rst_b = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wdata = 0, resp;
    logic [5:0] pOwn = 0, pDrv = 0, pOut = 0, extLevel = 6'h3f, extDrive = 0, d, l, e, p, q, r;
    logic dbg = 1, oc = 0, iMask = 1, xMask = 1, ack = 0;
    wire awr, wr_, bv, arr, rv, edgeIrq, extIrq, nmiIrq, strap;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [5:0] pinIn, pinOut, oeB, pullUpEn, pullDnEn, lowDrv, pIn;
    integer error_cnt = 0, n_tests = 0, seed = 21556, i;
    always #5 clk = ~clk;
    ppio_port ppio_port_inst (.clk, .rst_b, .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .pinIn, .pinOut,
        .pinOe_b(oeB), .pullUpEn, .pullDnEn, .lowDrive(lowDrv), .periphOwn(pOwn),
        .periphDrive(pDrv), .periphOut(pOut), .periphIn(pIn), .debugPinIn(dbg),
        .overCurrentIn(oc), .cpuIMask(iMask), .cpuXMask(xMask), .extAck(ack), .edgeIrq,
        .extIrq, .nmiIrq, .resetModeStrap(strap));
    ppio_pin_model ppio_pin_model_inst (.clk, .pinOut, .pinOe_b(oeB), .pullUpEn, .pullDnEn,
        .extLevel, .extDrive, .pinIn);
    function automatic logic [5:0] padv(input logic [5:0] dir, lat, ext);
        return (dir & lat) | (~dir & ext);
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        awa <= a;
        wdata <= v;
        awv <= 1;
        wv <= 1;
        do begin
            @(posedge clk);
            if (awr === 1) awv <= 0;
            if (wr_ === 1) wv <= 0;
            // late bready exercises the held answer
            if (bv === 1 && !bready) bready <= 1;
        end while (!(bv === 1 && bready));
        resp = bresp;
        bready <= 0;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] x, input logic [1:0] xr);
        ara <= a;
        arv <= 1;
        do begin
            @(posedge clk);
            if (arr === 1) arv <= 0;
            if (rv === 1 && !rready) rready <= 1;
        end while (!(rv === 1 && rready));
        rready <= 0;
        chk(rdata, x);
        chk(rresp, xr);
    endtask
    task pulse(input logic v, input integer n);
        extLevel[1] <= v;
        repeat (n) @(posedge clk);
    endtask
    task tally_and_finish;
        $display("errors %0d of %0d checks", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1;
        dbg <= 0;
        repeat (4) @(posedge clk);
        chk(oeB, 6'h3f);
        chk(pullUpEn, 6'h21);
        chk(strap, 1);
        rdc(`PPIO_OFF_STATUS, 2, 0);
        rdc(`PPIO_OFF_PULLEN, 32'h21, 0);
        rdc(8'h2c, 0, 2);
        wr(8'h2c, 1);
        chk(resp, 2);
        for (i = 0; i < 12; i++) begin
            {d, l, e} = 18'($random(seed));
            {p, q, r} = 18'($random(seed));
            extDrive <= ~d;
            extLevel <= e;
            wr(`PPIO_OFF_LATCH, l);
            wr(`PPIO_OFF_DIR, d);
            wr(`PPIO_OFF_DRIVE, r);
            wr(`PPIO_OFF_PULLEN, p);
            wr(`PPIO_OFF_POL, q);
            repeat (5) @(posedge clk);
            rdc(`PPIO_OFF_LATCH, padv(d, l, e), 0);
            rdc(`PPIO_OFF_INPUT, padv(d, l, e), 0);
            chk(oeB, 6'(~d));
            chk(pinOut & d, l & d);
            chk(lowDrv & d, r & d);
            chk(pullUpEn, 6'(p & ~d & ~q));
            chk(pullDnEn, 6'(p & ~d & q));
        end
        wr(`PPIO_OFF_DIR, 32'h3f);
        wr(`PPIO_OFF_LATCH, 32'h2a);
        pOut <= 6'($random(seed));
        pOwn <= 6'h3f;
        pDrv <= 6'h0f;
        extDrive <= 6'h30;
        repeat (5) @(posedge clk);
        chk(oeB, 6'h30);
        chk(pinOut[3:0], pOut[3:0]);
        chk(lowDrv[3:0], r[3:0]);
        chk(pIn[5:4], extLevel[5:4]);
        rdc(`PPIO_OFF_LATCH, 32'h2a, 0);
        pOwn <= 0;
        wr(`PPIO_OFF_ODRAIN, 32'h3f);
        wr(`PPIO_OFF_POL, 32'h3f);
        wr(`PPIO_OFF_PULLEN, 32'h3f);
        repeat (3) @(posedge clk);
        chk(oeB, 6'h2a);
        chk(pullDnEn, 0);
        wr(`PPIO_OFF_ODRAIN, 0);
        wr(`PPIO_OFF_DIR, 0);
        wr(`PPIO_OFF_POL, 0);
        extDrive <= 6'h3f;
        extLevel <= 6'h3f;
        repeat (8) @(posedge clk);
        wr(`PPIO_OFF_IFLAG, 32'h3f);
        pulse(0, 3);
        pulse(1, 8);
        rdc(`PPIO_OFF_IFLAG, 0, 0);
        pulse(0, 4);
        pulse(1, 8);
        rdc(`PPIO_OFF_IFLAG, 2, 0);
        chk(edgeIrq, 0);
        wr(`PPIO_OFF_IEN, 2);
        repeat (2) @(posedge clk);
        chk(edgeIrq, 1);
        wr(`PPIO_OFF_IFLAG, 32'h3d);
        rdc(`PPIO_OFF_IFLAG, 2, 0);
        wr(`PPIO_OFF_IFLAG, 2);
        repeat (2) @(posedge clk);
        chk(edgeIrq, 0);
        wr(`PPIO_OFF_POL, 2);
        // a high pin looks like a fresh edge once rising is chosen
        pulse(1, 6);
        wr(`PPIO_OFF_IFLAG, 2);
        pulse(0, 8);
        rdc(`PPIO_OFF_IFLAG, 0, 0);
        pulse(1, 8);
        rdc(`PPIO_OFF_IFLAG, 2, 0);
        extLevel <= 6'h1e;
        iMask <= 0;
        xMask <= 0;
        wr(`PPIO_OFF_EXTCTL, 2);
        repeat (4) @(posedge clk);
        chk(extIrq, 1);
        chk(nmiIrq, 1);
        iMask <= 1;
        xMask <= 1;
        repeat (3) @(posedge clk);
        chk({extIrq, nmiIrq}, 0);
        iMask <= 0;
        wr(`PPIO_OFF_EXTCTL, 0);
        repeat (3) @(posedge clk);
        chk(extIrq, 0);
        extLevel[5] <= 1;
        wr(`PPIO_OFF_EXTCTL, 3);
        repeat (2) @(posedge clk);
        chk(extIrq, 0);
        extLevel[5] <= 0;
        repeat (6) @(posedge clk);
        chk(extIrq, 1);
        ack <= 1;
        @(posedge clk);
        ack <= 0;
        repeat (3) @(posedge clk);
        chk(extIrq, 0);
        oc <= 1;
        repeat (4) @(posedge clk);
        oc <= 0;
        repeat (2) @(posedge clk);
        chk({oeB[2], pinOut[2]}, 0);
        rdc(`PPIO_OFF_STATUS, 3, 0);
        wr(`PPIO_OFF_STATUS, 1);
        repeat (2) @(posedge clk);
        chk(oeB[2], 1);
        // second reset: strap must now follow the low debug pin
        rst_b <= 0;
        repeat (3) @(posedge clk);
        rst_b <= 1;
        repeat (2) @(posedge clk);
        chk(strap, 0);
        rdc(`PPIO_OFF_STATUS, 0, 0);
        rdc(`PPIO_OFF_PULLEN, 32'h21, 0);
        tally_and_finish;
    end
endmodule
